/* logic/guard_pkg.sv */
// constants, field positions and types of the special register write guard
//------------------------------------------------------------------------------
// Summary of operation
// - only the first write after a command write reaches a protected register
// - command register takes 8-bit writes only and reads back no stored data
// - power-save, clock and watchdog mode registers are the only guarded ones
// - reads need no sequence and leave the window armed, though one inside it bars a watchdog write
// - any data value written to the command register arms the window
// - interrupt acknowledge is held off while the window is armed
// - protected write without a preceding command write sets the error flag
// - armed window followed by a write elsewhere sets the error flag
// - reads inside the window keep it armed for power-save and clock registers
// - writing 0 to the error flag clears it
// - reset clears the error flag
// - clearing write right after a command write beats the error set
// - two command writes back to back set the error flag
// - system status register accepts byte and single-bit accesses
//------------------------------------------------------------------------------
package guard_pkg;

  // register byte offsets on the wishbone port
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_PSC = 8'h04;
  localparam logic [7:0] OFF_PCC = 8'h08;
  localparam logic [7:0] OFF_WDT = 8'h0C;
  localparam logic [7:0] OFF_SYS = 8'h10;
  localparam logic [7:0] OFF_WAIT = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

  // values after reset, and the fixed read value of the command register
  localparam logic [7:0] RST_PSC = 8'h00;
  localparam logic [7:0] RST_PCC = 8'h00;
  localparam logic [7:0] RST_WDT = 8'h00;
  localparam logic [7:0] RST_WAIT = 8'h77;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] CMD_READ_VALUE = 8'h00;

  // field positions
  localparam int ERR_BIT = 0;
  localparam int STOP_SELECT_BIT = 1;
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_ACCEPT_BIT = 1;

  // bit manipulation opcodes carried beside a write
  localparam logic [1:0] BIT_NONE = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_CLR = 2'h2;
  localparam logic [1:0] BIT_NOT = 2'h3;

  // classification of one bus cycle for the sequencer
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_CMD,
    TGT_PROT_FREE,
    TGT_PROT_WDT,
    TGT_SYS_CLR,
    TGT_OTHER
  } target_t;

  typedef enum logic {
    WIN_IDLE,
    WIN_ARMED
  } window_state_t;

endpackage

/* logic/guard_window_if.sv */
// carrier between the bus front end and the write window sequencer
`timescale 1ns/1ns
`default_nettype none
interface guard_window_if;
  logic wr_pulse;
  logic rd_pulse;
  guard_pkg::target_t kind;
  logic accept;
  logic err_set;
  logic armed;

  modport ctrl (output wr_pulse, output rd_pulse, output kind, input accept, input err_set, input armed);
  modport seq (input wr_pulse, input rd_pulse, input kind, output accept, output err_set, output armed);
endinterface
`default_nettype wire

/* logic/window_sequencer.sv */
// one-shot write window armed by the command register
`timescale 1ns/1ns
`default_nettype none
module window_sequencer (
  input wire logic i_clk,         // system clock
  input wire logic i_rst,         // synchronous reset, active high
  guard_window_if.seq win         // classified bus cycles in, verdicts out
);

  guard_pkg::window_state_t state_reg;
  guard_pkg::window_state_t state_next;
  logic read_seen_reg;
  logic read_seen_next;

  //----------------------------------------------------------------------------
  // verdict and next state
  //----------------------------------------------------------------------------
  // a read inside the window is remembered: the watchdog register does not
  // tolerate one, the other two guarded registers do
  always_comb begin
    state_next = state_reg;
    read_seen_next = read_seen_reg;
    win.accept = 1'b0;
    win.err_set = 1'b0;
    if (state_reg == guard_pkg::WIN_ARMED && win.rd_pulse) begin
      read_seen_next = 1'b1;
    end
    if (win.wr_pulse) begin
      case (win.kind)
        guard_pkg::TGT_CMD: begin
          if (state_reg == guard_pkg::WIN_ARMED) begin
            win.err_set = 1'b1;
            state_next = guard_pkg::WIN_IDLE;
          end else begin
            state_next = guard_pkg::WIN_ARMED;
            read_seen_next = 1'b0;
          end
        end
        guard_pkg::TGT_PROT_FREE: begin
          win.accept = (state_reg == guard_pkg::WIN_ARMED);
          win.err_set = (state_reg == guard_pkg::WIN_IDLE);
          state_next = guard_pkg::WIN_IDLE;
        end
        guard_pkg::TGT_PROT_WDT: begin
          win.accept = (state_reg == guard_pkg::WIN_ARMED) && !read_seen_reg;
          win.err_set = !win.accept;
          state_next = guard_pkg::WIN_IDLE;
        end
        guard_pkg::TGT_SYS_CLR: begin
          state_next = guard_pkg::WIN_IDLE;
        end
        guard_pkg::TGT_OTHER: begin
          win.err_set = (state_reg == guard_pkg::WIN_ARMED);
          state_next = guard_pkg::WIN_IDLE;
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  assign win.armed = (state_reg == guard_pkg::WIN_ARMED);

  //----------------------------------------------------------------------------
  // state registers
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= guard_pkg::WIN_IDLE;
      read_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      read_seen_reg <= read_seen_next;
    end
  end

endmodule
`default_nettype wire

/* logic/special_register_write_guard.sv */
// wishbone front end, guarded registers and status of the write guard
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module special_register_write_guard (
  input wire logic I_SYS_CLK,            // 50 MHz system clock
  input wire logic I_RST,                // synchronous reset, active high
  input wire logic I_WB_CYC,             // wishbone cycle
  input wire logic I_WB_STB,             // wishbone strobe
  input wire logic I_WB_WE,              // wishbone write enable
  input wire logic [7:0] I_WB_ADR,       // byte address
  input wire logic [3:0] I_WB_SEL,       // byte lane selects
  input wire logic [31:0] I_WB_DAT,      // write data
  input wire logic [1:0] I_BIT_OP,       // bit op beside a write, 0 = plain store
  input wire logic [2:0] I_BIT_POS,      // bit number for the bit op
  output logic [31:0] O_WB_DAT,          // read data
  output logic O_WB_ACK,                 // wishbone acknowledge
  output logic O_IRQ,                    // level interrupt
  output logic O_IRQ_ACK_INHIBIT,        // hold off interrupt acknowledge
  output logic [7:0] O_POWER_SAVE_CTRL,  // power-save control value
  output logic [7:0] O_CLOCK_CTRL,       // processor clock control value
  output logic [7:0] O_WATCHDOG_MODE,    // watchdog mode value
  output logic [7:0] O_WAIT_CTRL,        // peripheral wait control value
  output logic O_STOP_SELECT,            // stop select bit of power-save control
  output logic O_PROT_ERROR              // protection error flag
);

  logic ack_reg;
  logic [31:0] rd_data_reg;
  logic [7:0] psc_reg;
  logic [7:0] pcc_reg;
  logic [7:0] wdt_reg;
  logic [7:0] wait_reg;
  logic err_reg;
  logic err_next;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_stat_next;
  logic [7:0] irq_mask_reg;

  guard_window_if win ();

  //----------------------------------------------------------------------------
  // bus decode
  //----------------------------------------------------------------------------
  // a cycle is taken once, in the cycle before ack rises
  wire take = I_WB_CYC && I_WB_STB && !ack_reg;
  wire wr = take && I_WB_WE;
  wire rd = take && !I_WB_WE;
  wire bit_op = (I_BIT_OP != guard_pkg::BIT_NONE);
  wire lane0 = I_WB_SEL[0] || bit_op;
  wire byte_only = (I_WB_SEL == 4'h1) && !bit_op;
  wire hit_cmd = (I_WB_ADR[7:2] == guard_pkg::OFF_CMD[7:2]);
  wire hit_psc = (I_WB_ADR[7:2] == guard_pkg::OFF_PSC[7:2]);
  wire hit_pcc = (I_WB_ADR[7:2] == guard_pkg::OFF_PCC[7:2]);
  wire hit_wdt = (I_WB_ADR[7:2] == guard_pkg::OFF_WDT[7:2]);
  wire hit_sys = (I_WB_ADR[7:2] == guard_pkg::OFF_SYS[7:2]);
  wire hit_wait = (I_WB_ADR[7:2] == guard_pkg::OFF_WAIT[7:2]);
  wire hit_stat = (I_WB_ADR[7:2] == guard_pkg::OFF_IRQ_STAT[7:2]);
  wire hit_mask = (I_WB_ADR[7:2] == guard_pkg::OFF_IRQ_MASK[7:2]);

  //----------------------------------------------------------------------------
  // current byte of the addressed register
  //----------------------------------------------------------------------------
  // the command register never returns what was written to it
  wire [7:0] sys_byte = {7'h00, err_reg};
  wire [7:0] cur_byte =
    hit_cmd ? guard_pkg::CMD_READ_VALUE :
    hit_psc ? psc_reg :
    hit_pcc ? pcc_reg :
    hit_wdt ? wdt_reg :
    hit_sys ? sys_byte :
    hit_wait ? wait_reg :
    hit_stat ? irq_stat_reg :
    hit_mask ? irq_mask_reg : 8'h00;

  //----------------------------------------------------------------------------
  // store data: plain byte or read-modify-write of one bit
  //----------------------------------------------------------------------------
  // bit ops act on lane 0 only; every register here is a byte wide
  wire [7:0] bit_mask = 8'(8'h01 << I_BIT_POS);
  wire [7:0] new_byte =
    (I_BIT_OP == guard_pkg::BIT_SET) ? (cur_byte | bit_mask) :
    (I_BIT_OP == guard_pkg::BIT_CLR) ? (cur_byte & ~bit_mask) :
    (I_BIT_OP == guard_pkg::BIT_NOT) ? (cur_byte ^ bit_mask) : I_WB_DAT[7:0];

  //----------------------------------------------------------------------------
  // classification for the sequencer
  //----------------------------------------------------------------------------
  // a wide or bit-op store to the command register does not arm, yet it is
  // still a peripheral write and so closes an open window
  wire sys_clr = hit_sys && lane0 && !new_byte[guard_pkg::ERR_BIT];
  assign win.wr_pulse = wr;
  assign win.rd_pulse = rd;
  assign win.kind =
    !wr ? guard_pkg::TGT_NONE :
    hit_cmd ? (byte_only ? guard_pkg::TGT_CMD : guard_pkg::TGT_OTHER) :
    (hit_psc || hit_pcc) ? guard_pkg::TGT_PROT_FREE :
    hit_wdt ? guard_pkg::TGT_PROT_WDT :
    sys_clr ? guard_pkg::TGT_SYS_CLR : guard_pkg::TGT_OTHER;

  window_sequencer u_seq (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .win(win)
  );

  //----------------------------------------------------------------------------
  // register write enables
  //----------------------------------------------------------------------------
  wire prot_load = win.accept && lane0;
  wire psc_we = prot_load && hit_psc;
  wire pcc_we = prot_load && hit_pcc;
  wire wdt_we = prot_load && hit_wdt;
  wire wait_we = wr && lane0 && hit_wait;
  wire mask_we = wr && lane0 && hit_mask;
  wire stat_rd = rd && hit_stat;

  //----------------------------------------------------------------------------
  // error flag and sticky event bits
  //----------------------------------------------------------------------------
  // hardware set wins over clear, except the clearing store right after a
  // command write, where the sequencer raises no set at all
  always_comb begin
    err_next = err_reg;
    if (win.err_set) begin
      err_next = 1'b1;
    end else if (wr && sys_clr) begin
      err_next = 1'b0;
    end
  end

  // a read of the status register clears it, new events in that cycle survive
  always_comb begin
    irq_stat_next = stat_rd ? 8'h00 : irq_stat_reg;
    if (win.err_set) begin
      irq_stat_next[guard_pkg::IRQ_ERR_BIT] = 1'b1;
    end
    if (prot_load) begin
      irq_stat_next[guard_pkg::IRQ_ACCEPT_BIT] = 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // guarded registers
  //----------------------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      psc_reg <= guard_pkg::RST_PSC;
      pcc_reg <= guard_pkg::RST_PCC;
      wdt_reg <= guard_pkg::RST_WDT;
    end else begin
      if (psc_we) begin
        psc_reg <= new_byte;
      end
      if (pcc_we) begin
        pcc_reg <= new_byte;
      end
      if (wdt_we) begin
        wdt_reg <= new_byte;
      end
    end
  end

  //----------------------------------------------------------------------------
  // unguarded registers and status
  //----------------------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      wait_reg <= guard_pkg::RST_WAIT;
      irq_mask_reg <= guard_pkg::RST_IRQ_MASK;
      err_reg <= 1'b0;
      irq_stat_reg <= 8'h00;
    end else begin
      if (wait_we) begin
        wait_reg <= new_byte;
      end
      if (mask_we) begin
        irq_mask_reg <= new_byte;
      end
      err_reg <= err_next;
      irq_stat_reg <= irq_stat_next;
    end
  end

  //----------------------------------------------------------------------------
  // bus answer
  //----------------------------------------------------------------------------
  // one wait state on every access, unmapped addresses read zero and are
  // acked so a stray pointer cannot hang the core
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ack_reg <= 1'b0;
      rd_data_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= take;
      if (rd) begin
        rd_data_reg <= {24'h00_0000, cur_byte};
      end
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  // the core must not take an interrupt between the command store and the
  // guarded store, so acknowledge is blocked while the window is open
  assign O_IRQ_ACK_INHIBIT = win.armed;
  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rd_data_reg;
  assign O_IRQ = |(irq_stat_reg & irq_mask_reg);
  assign O_POWER_SAVE_CTRL = psc_reg;
  assign O_CLOCK_CTRL = pcc_reg;
  assign O_WATCHDOG_MODE = wdt_reg;
  assign O_WAIT_CTRL = wait_reg;
  assign O_STOP_SELECT = psc_reg[guard_pkg::STOP_SELECT_BIT];
  assign O_PROT_ERROR = err_reg;

endmodule
`default_nettype wire

/* sim/guard_properties.sv */
// port-level checks of the special register write guard
`timescale 1ns/1ns
`default_nettype none
module guard_properties (
  input wire logic I_SYS_CLK, // clock
  input wire logic I_RST, // sync reset
  input wire logic I_WB_CYC, // cycle
  input wire logic I_WB_STB, // strobe
  input wire logic I_WB_WE, // write
  input wire logic [7:0] I_WB_ADR, // address
  input wire logic [3:0] I_WB_SEL, // lanes
  input wire logic [31:0] I_WB_DAT, // write data
  input wire logic [1:0] I_BIT_OP, // bit op
  input wire logic O_WB_ACK, // ack
  input wire logic O_IRQ_ACK_INHIBIT, // window armed
  input wire logic [7:0] O_POWER_SAVE_CTRL, // power-save value
  input wire logic O_PROT_ERROR // error flag
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // decode of the request taken at this edge; the ack term keeps a held request from counting twice
  wire taken = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire wr = taken && I_WB_WE;
  wire [5:0] word = I_WB_ADR[7:2];
  wire plain0 = I_WB_SEL[0] && I_BIT_OP == guard_pkg::BIT_NONE;
  wire cmd_wr = wr && word == guard_pkg::OFF_CMD[7:2] && I_WB_SEL == 4'h1 && I_BIT_OP == guard_pkg::BIT_NONE;
  wire psc_wr = wr && word == guard_pkg::OFF_PSC[7:2];
  a_ack_next:
    assert property (taken |=> O_WB_ACK) else $error("no ack one cycle after request");
  a_ack_pulse:
    assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack longer than one cycle");
  a_cmd_arms:
    assert property (cmd_wr && !O_IRQ_ACK_INHIBIT |=> O_IRQ_ACK_INHIBIT) else $error("command write did not arm");
  a_double_cmd:
    assert property (cmd_wr && O_IRQ_ACK_INHIBIT |=> O_PROT_ERROR && !O_IRQ_ACK_INHIBIT) else $error("double command");
  a_write_consumes:
    assert property (wr && O_IRQ_ACK_INHIBIT |=> !O_IRQ_ACK_INHIBIT) else $error("window survived a write");
  a_read_neutral:
    assert property (taken && !I_WB_WE |=> $stable(O_IRQ_ACK_INHIBIT) && $stable(O_PROT_ERROR))
      else $error("read changed guard state");
  a_unarmed_refused:
    assert property (psc_wr && !O_IRQ_ACK_INHIBIT |=> O_PROT_ERROR && $stable(O_POWER_SAVE_CTRL))
      else $error("unarmed guarded write");
  a_armed_store:
    assert property (psc_wr && plain0 && O_IRQ_ACK_INHIBIT |=> O_POWER_SAVE_CTRL == $past(I_WB_DAT[7:0]))
      else $error("armed store lost");
  a_clear_wins:
    assert property (wr && word == guard_pkg::OFF_SYS[7:2] && plain0 && !I_WB_DAT[0] |=> !O_PROT_ERROR)
      else $error("error flag not cleared");
  a_other_err:
    assert property (wr && word == guard_pkg::OFF_WAIT[7:2] && O_IRQ_ACK_INHIBIT |=> O_PROT_ERROR)
      else $error("write elsewhere not flagged");
  a_reset_clears:
    assert property (disable iff (1'b0) I_RST |=> !O_PROT_ERROR) else $error("reset left error set");
endmodule
bind special_register_write_guard guard_properties chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
  .I_WB_DAT(I_WB_DAT), .I_BIT_OP(I_BIT_OP), .O_WB_ACK(O_WB_ACK), .O_IRQ_ACK_INHIBIT(O_IRQ_ACK_INHIBIT),
  .O_POWER_SAVE_CTRL(O_POWER_SAVE_CTRL), .O_PROT_ERROR(O_PROT_ERROR));
`default_nettype wire

/* sim/cpu_store_model.sv */
// behavioural cpu core issuing loads and stores over classic wishbone
`timescale 1ns/1ns
`default_nettype none
module cpu_store_model (
  input wire logic i_clk, // clock
  input wire logic i_ack, // ack
  input wire logic [31:0] i_dat, // read data
  output logic o_cyc, // cycle
  output logic o_stb, // strobe
  output logic o_we, // write
  output logic [7:0] o_adr, // address
  output logic [3:0] o_sel, // lanes
  output logic [31:0] o_dat, // write data
  output logic [1:0] o_op, // bit op
  output logic [2:0] o_pos // bit number
);
  initial begin
    {o_cyc, o_stb, o_we} = 3'h0;
    {o_adr, o_sel, o_dat, o_op, o_pos} = '0;
  end
  // one single cycle; waits for ack however many cycles it takes, only the bench watchdog ends a hang
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] op, input logic [2:0] pos, output logic [7:0] q);
    @(posedge i_clk);
    {o_cyc, o_stb, o_we} <= {2'b11, we};
    {o_adr, o_sel, o_dat, o_op, o_pos} <= {a, s, 24'h0, d, op, pos};
    do @(posedge i_clk); while (i_ack !== 1'b1);
    q = i_dat[7:0];
    {o_cyc, o_stb} <= 2'b00;
    // released address and data lines take the inverse so stale values never look live
    {o_adr, o_dat} <= {~a, ~{24'h0, d}};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'h1, 2'h0, 3'h0, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, 4'h1, 2'h0, 3'h0, q);
  endtask
  // command write with the same data, then the guarded store, then five idle steps
  task automatic guarded(input logic [7:0] a, input logic [7:0] d, input logic [1:0] op, input logic [2:0] pos);
    logic [7:0] q;
    wr(guard_pkg::OFF_CMD, d);
    bus(1'b1, a, d, 4'h1, op, pos, q);
    repeat (5) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* sim/special_register_write_guard_bench.sv */
// self-checking bench of the special register write guard
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module special_register_write_guard_bench;
  logic clk, rst, cyc, stb, we, ack, irq, inhib, stop, err;
  logic [7:0] adr, power_save_control_reg, processor_clock_control_reg, wdt, wait_v, q, d;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [1:0] op, o;
  logic [2:0] pos, p;
  logic [7:0] model [3];
  int bad_count, n_checks, i, j;
  special_register_write_guard DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_BIT_OP(op), .I_BIT_POS(pos), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_IRQ(irq), .O_IRQ_ACK_INHIBIT(inhib), .O_POWER_SAVE_CTRL(power_save_control_reg), .O_CLOCK_CTRL(processor_clock_control_reg),
    .O_WATCHDOG_MODE(wdt), .O_WAIT_CTRL(wait_v), .O_STOP_SELECT(stop), .O_PROT_ERROR(err));
  cpu_store_model cpu (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_sel(sel), .o_dat(wdat), .o_op(op), .o_pos(pos));
  // expected register value after a plain store or a bit op
  function automatic logic [7:0] apply(input logic [7:0] v, input logic [7:0] dd, input logic [1:0] oo,
                                       input logic [2:0] pp);
    case (oo)
      guard_pkg::BIT_SET: apply = v | (8'h01 << pp);
      guard_pkg::BIT_CLR: apply = v & ~(8'h01 << pp);
      guard_pkg::BIT_NOT: apply = v ^ (8'h01 << pp);
      default: apply = dd;
    endcase
  endfunction
  function automatic logic [7:0] addr_of(input int k);
    return (k == 0) ? guard_pkg::OFF_PSC : (k == 1) ? guard_pkg::OFF_PCC : guard_pkg::OFF_WDT;
  endfunction
  function automatic logic [7:0] out_of(input int k);
    return (k == 0) ? power_save_control_reg : (k == 1) ? processor_clock_control_reg : wdt;
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run needs about 310 cycles; this cuts a stuck handshake short
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bad_count = 0;
    n_checks = 0;
    model = '{8'h00, 8'h00, 8'h00};
    void'($urandom(32'h8ccd));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({err, inhib, irq, wait_v}, {3'b000, guard_pkg::RST_WAIT});
    cpu.wr(guard_pkg::OFF_WAIT, 8'h01);
    cpu.rd(guard_pkg::OFF_CMD, q);
    `CHK(q, guard_pkg::CMD_READ_VALUE);
    cpu.rd(guard_pkg::OFF_PSC, q);
    `CHK({q, err, inhib}, {guard_pkg::RST_PSC, 2'b00});
    cpu.wr(guard_pkg::OFF_IRQ_MASK, 8'h01);
    cpu.wr(guard_pkg::OFF_PCC, 8'h5A);
    `CHK({err, irq, processor_clock_control_reg}, {2'b11, 8'h00});
    cpu.rd(guard_pkg::OFF_IRQ_STAT, q);
    `CHK({q, irq}, {8'h01, 1'b0});
    cpu.wr(guard_pkg::OFF_SYS, 8'h00);
    `CHK(err, 1'b0);
    $display("test reset_and_unarmed done");
    for (i = 0; i < 12; i++) begin
      j = $urandom_range(2, 0);
      d = 8'($urandom);
      o = 2'($urandom);
      p = 3'($urandom);
      cpu.guarded(addr_of(j), d, o, p);
      model[j] = apply(model[j], d, o, p);
      `CHK({err, out_of(j)}, {1'b0, model[j]});
      `CHK(stop, model[0][guard_pkg::STOP_SELECT_BIT]);
      cpu.wr(addr_of(j), ~d);
      `CHK({err, out_of(j)}, {1'b1, model[j]});
      cpu.wr(guard_pkg::OFF_SYS, 8'h00);
    end
    cpu.rd(guard_pkg::OFF_IRQ_STAT, q);
    `CHK(q, 8'h03);
    $display("test random_guarded done");
    cpu.wr(guard_pkg::OFF_CMD, 8'($urandom));
    `CHK(inhib, 1'b1);
    cpu.rd(guard_pkg::OFF_PSC, q);
    cpu.wr(guard_pkg::OFF_PCC, 8'hC3);
    `CHK({err, inhib, processor_clock_control_reg}, {2'b00, 8'hC3});
    cpu.wr(guard_pkg::OFF_CMD, 8'h00);
    cpu.rd(guard_pkg::OFF_PSC, q);
    cpu.wr(guard_pkg::OFF_WDT, 8'h11);
    `CHK({err, wdt}, {1'b1, model[2]});
    cpu.wr(guard_pkg::OFF_CMD, 8'hFF);
    cpu.wr(guard_pkg::OFF_SYS, 8'h00);
    `CHK({err, inhib}, 2'b00);
    cpu.wr(guard_pkg::OFF_CMD, 8'h00);
    cpu.wr(guard_pkg::OFF_CMD, 8'h00);
    `CHK({err, inhib}, 2'b10);
    cpu.wr(guard_pkg::OFF_SYS, 8'h00);
    cpu.wr(guard_pkg::OFF_CMD, 8'h00);
    cpu.wr(8'h3C, 8'hFF);
    `CHK(err, 1'b1);
    cpu.wr(guard_pkg::OFF_SYS, 8'h00);
    cpu.wr(guard_pkg::OFF_CMD, 8'h00);
    cpu.wr(guard_pkg::OFF_WAIT, 8'h01);
    `CHK({err, wait_v}, {1'b1, 8'h01});
    $display("test sequences done");
    cpu.bus(1'b1, guard_pkg::OFF_CMD, 8'hA5, 4'hF, guard_pkg::BIT_NONE, 3'h0, q);
    `CHK(inhib, 1'b0);
    cpu.bus(1'b1, guard_pkg::OFF_SYS, 8'hFF, 4'h0, guard_pkg::BIT_CLR, 3'h0, q);
    `CHK(err, 1'b0);
    cpu.wr(guard_pkg::OFF_PSC, 8'h02);
    `CHK({err, power_save_control_reg}, {1'b1, model[0]});
    cpu.rd(guard_pkg::OFF_IRQ_STAT, q);
    cpu.wr(guard_pkg::OFF_IRQ_MASK, 8'h00);
    cpu.wr(guard_pkg::OFF_WDT, 8'h22);
    `CHK(irq, 1'b0);
    cpu.rd(guard_pkg::OFF_IRQ_STAT, q);
    `CHK(q, 8'h01);
    $display("test width_and_irq done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({err, power_save_control_reg, wait_v}, {1'b0, guard_pkg::RST_PSC, guard_pkg::RST_WAIT});
    $display("test mid_reset done");
    finish_test;
  end
endmodule
`default_nettype wire
